// *** intvec_resolver.sv ***
// Purpose: Maps interrupt sources to vectors and resolves the winner.
// Assumes: Request inputs are levels synchronous to clock_i.
// Notes: Result is registered; it follows requests one cycle later.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`default_nettype none

module intvec_resolver
    import intvec_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire req_t req_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output grant_t grant_o
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] level_a_reg;
    logic [7:0] level_b_reg;
    logic wide_reg;
    logic [7:0] rdata_reg;
    grant_t grant_reg;
    grant_t grant_next;
    logic [15:0] levels;
    logic [63:0] pend;
    logic [63:0] hi_pend;
    logic [6:0] hi_pick;
    logic [6:0] any_pick;

    assign levels = {level_a_reg, level_b_reg};

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_a_reg <= LEVEL_RESET;
            level_b_reg <= LEVEL_RESET;
        end else if (wr_i && addr_i == OFS_LEVEL_A) begin
            level_a_reg <= wdata_i & LEVEL_A_MASK;
        end else if (wr_i && addr_i == OFS_LEVEL_B) begin
            level_b_reg <= wdata_i & LEVEL_B_MASK;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wide_reg <= 1'b0;
        end else if (wr_i && addr_i == OFS_CONTROL) begin
            wide_reg <= wdata_i[CTRL_WIDE_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                OFS_LEVEL_A: rdata_reg <= level_a_reg;
                OFS_LEVEL_B: rdata_reg <= level_b_reg;
                OFS_CONTROL: rdata_reg <= {7'h00, wide_reg};
                OFS_STATUS: rdata_reg <= {grant_reg.valid, grant_reg.is_nmi, grant_reg.vector};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Source to vector map
    // ****************************************
    always_comb begin
        pend = 64'h0;
        hi_pend = 64'h0;
        pend[VEC_EXT0] = req_i.ext0_req;
        hi_pend[VEC_EXT0] = levels[LVL_EXT0];
        pend[VEC_EXT1] = req_i.ext1_req;
        hi_pend[VEC_EXT1] = levels[LVL_EXT1];
        pend[VEC_EXT4] = req_i.ext4_req;
        pend[VEC_EXT5] = req_i.ext5_req;
        hi_pend[VEC_EXT4] = levels[LVL_EXT45];
        hi_pend[VEC_EXT5] = levels[LVL_EXT45];
        pend[VEC_WDT] = req_i.watchdog_interval_req;
        hi_pend[VEC_WDT] = levels[LVL_WDT];
        // Timer channels: A, B, overflow, then a reserved slot
        for (int n = 0; n < NUM_TMR; n++) begin
            pend[VEC_TMR_BASE + VEC_STRIDE * n] = req_i.timer_match_a_req[n];
            pend[VEC_TMR_BASE + VEC_STRIDE * n + 1] = req_i.timer_match_b_req[n];
            pend[VEC_TMR_BASE + VEC_STRIDE * n + 2] = req_i.timer_overflow_req[n];
            for (int k = 0; k < 3; k++) begin
                hi_pend[VEC_TMR_BASE + VEC_STRIDE * n + k] = levels[LVL_TMR0 - n];
            end
        end
        for (int n = 0; n < NUM_SER; n++) begin
            pend[VEC_SER_BASE + VEC_STRIDE * n] = req_i.serial_rx_error_req[n];
            pend[VEC_SER_BASE + VEC_STRIDE * n + 1] = req_i.serial_rx_full_req[n];
            pend[VEC_SER_BASE + VEC_STRIDE * n + 2] = req_i.serial_tx_empty_req[n];
            pend[VEC_SER_BASE + VEC_STRIDE * n + 3] = req_i.serial_tx_end_req[n];
            for (int k = 0; k < 4; k++) begin
                hi_pend[VEC_SER_BASE + VEC_STRIDE * n + k] = levels[LVL_SER0 - n];
            end
        end
        pend[VEC_ADC] = req_i.conversion_end_req;
        hi_pend[VEC_ADC] = levels[LVL_ADC];
        hi_pend = hi_pend & pend;
    end

    // ****************************************
    // Resolution
    // ****************************************
    assign hi_pick = first_set(hi_pend);
    assign any_pick = first_set(pend);

    always_comb begin
        grant_next = '0;
        if (req_i.nmi_req) begin
            grant_next.valid = 1'b1;
            grant_next.is_nmi = 1'b1;
            grant_next.vector = VEC_NMI;
        end else if (hi_pick[6]) begin
            grant_next.valid = 1'b1;
            grant_next.vector = hi_pick[5:0];
        end else if (any_pick[6]) begin
            grant_next.valid = 1'b1;
            grant_next.vector = any_pick[5:0];
        end
        if (grant_next.valid) begin
            grant_next.address = {16'h0000, vec_addr(grant_next.vector, wide_reg)};
        end
    end

    // Losers are not stored; a held request wins again later
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grant_reg <= '0;
        end else begin
            grant_reg <= grant_next;
        end
    end

    assign grant_o = grant_reg;
    assign rdata_o = rdata_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_nmi_top_rank: assert property (
        req_i.nmi_req |=> grant_o.valid && grant_o.is_nmi && grant_o.vector == 6'h07
    ) else $error("nmi not granted at vector 7");

    a_default_order: assert property (
        !req_i.nmi_req && levels == 16'h0000 && req_i.ext0_req && req_i.ext1_req
        |=> grant_o.vector == 6'h0C
    ) else $error("default order broken");

    a_level_one_wins: assert property (
        !req_i.nmi_req && level_a_reg[4] && !level_a_reg[7] && !level_a_reg[6]
        && req_i.ext5_req && req_i.ext0_req && !req_i.ext4_req
        |=> grant_o.vector == 6'h11
    ) else $error("level one source did not win");

    a_addr_normal: assert property (
        grant_o.valid && !$past(wide_reg)
        |-> grant_o.address == {25'h0, grant_o.vector, 1'b0}
    ) else $error("normal mode address wrong");

    a_addr_wide: assert property (
        grant_o.valid && $past(wide_reg)
        |-> grant_o.address == {24'h0, grant_o.vector, 2'h0}
    ) else $error("wide mode address wrong");

    a_no_reserved: assert property (
        grant_o.valid && !grant_o.is_nmi |-> !(grant_o.vector inside
        {6'h0E, 6'h0F, 6'h12, 6'h13, [6'h15:6'h17], 6'h1B, 6'h1F, 6'h23, 6'h27, [6'h2B:6'h33]})
    ) else $error("reserved vector produced");

    a_hold_pending: assert property (
        (pend != 64'h0) ##1 (pend != 64'h0) |-> grant_o.valid
    ) else $error("pending request lost");

    a_adc_last: assert property (
        !req_i.nmi_req && pend == (64'h1 << 60) |=> grant_o.vector == 6'h3C
    ) else $error("conversion end vector wrong");

    a_timer_map: assert property (
        !req_i.nmi_req && levels == 16'h0000 && pend == (64'h1 << 26)
        |=> grant_o.vector == 6'h1A
    ) else $error("timer overflow vector wrong");

    a_winner_stands: assert property (
        $stable(req_i) && $stable(levels) && $stable(wide_reg) && grant_o.valid
        |=> $stable(grant_o)
    ) else $error("winner changed with steady inputs");

    a_adc_loses: assert property (
        levels == 16'h0000 && req_i.conversion_end_req && $countones(req_i) > 1
        |=> grant_o.vector != 6'h3C
    ) else $error("conversion end won over a level zero source");

    // ****************************************
    // Checks: each level bit, through one source per bit
    // ****************************************

    a_lvl_ext0: assert property (
        !req_i.nmi_req && levels == 16'h8000 && req_i.ext0_req
        |=> grant_o.vector == 6'h0C
    ) else $error("external 0 level bit wrong");

    a_lvl_ext1: assert property (
        !req_i.nmi_req && levels == 16'h4000 && req_i.ext1_req
        |=> grant_o.vector == 6'h0D
    ) else $error("external 1 level bit wrong");

    a_lvl_ext45: assert property (
        !req_i.nmi_req && levels == 16'h1000 && req_i.ext4_req
        |=> grant_o.vector == 6'h10
    ) else $error("external 4 and 5 level bit wrong");

    a_lvl_watchdog: assert property (
        !req_i.nmi_req && levels == 16'h0800 && req_i.watchdog_interval_req
        |=> grant_o.vector == 6'h14
    ) else $error("watchdog level bit wrong");

    a_lvl_tmr0: assert property (
        !req_i.nmi_req && levels == 16'h0400 && req_i.timer_match_a_req[0]
        |=> grant_o.vector == 6'h18
    ) else $error("timer 0 level bit wrong");

    a_lvl_tmr1: assert property (
        !req_i.nmi_req && levels == 16'h0200 && req_i.timer_match_a_req[1]
        |=> grant_o.vector == 6'h1C
    ) else $error("timer 1 level bit wrong");

    a_lvl_tmr2: assert property (
        !req_i.nmi_req && levels == 16'h0100 && req_i.timer_match_a_req[2]
        |=> grant_o.vector == 6'h20
    ) else $error("timer 2 level bit wrong");

    a_lvl_tmr3: assert property (
        !req_i.nmi_req && levels == 16'h0080 && req_i.timer_match_a_req[3]
        |=> grant_o.vector == 6'h24
    ) else $error("timer 3 level bit wrong");

    a_lvl_tmr4: assert property (
        !req_i.nmi_req && levels == 16'h0040 && req_i.timer_match_a_req[4]
        |=> grant_o.vector == 6'h28
    ) else $error("timer 4 level bit wrong");

    a_lvl_ser0: assert property (
        !req_i.nmi_req && levels == 16'h0008 && req_i.serial_rx_error_req[0]
        |=> grant_o.vector == 6'h34
    ) else $error("serial 0 level bit wrong");

    a_lvl_ser1: assert property (
        !req_i.nmi_req && levels == 16'h0004 && req_i.serial_rx_error_req[1]
        |=> grant_o.vector == 6'h38
    ) else $error("serial 1 level bit wrong");

    a_lvl_adc: assert property (
        !req_i.nmi_req && levels == 16'h0002 && req_i.conversion_end_req
        |=> grant_o.vector == 6'h3C
    ) else $error("conversion end level bit wrong");

    // ****************************************
    // Checks: vector of each lone source not checked above
    // ****************************************

    a_map_vec17: assert property (
        $onehot(req_i) && req_i.ext5_req |=> grant_o.vector == 6'h11
    ) else $error("vector 17 map wrong");

    a_map_vec25: assert property (
        $onehot(req_i) && req_i.timer_match_b_req[0] |=> grant_o.vector == 6'h19
    ) else $error("vector 25 map wrong");

    a_map_vec29: assert property (
        $onehot(req_i) && req_i.timer_match_b_req[1] |=> grant_o.vector == 6'h1D
    ) else $error("vector 29 map wrong");

    a_map_vec30: assert property (
        $onehot(req_i) && req_i.timer_overflow_req[1] |=> grant_o.vector == 6'h1E
    ) else $error("vector 30 map wrong");

    a_map_vec33: assert property (
        $onehot(req_i) && req_i.timer_match_b_req[2] |=> grant_o.vector == 6'h21
    ) else $error("vector 33 map wrong");

    a_map_vec34: assert property (
        $onehot(req_i) && req_i.timer_overflow_req[2] |=> grant_o.vector == 6'h22
    ) else $error("vector 34 map wrong");

    a_map_vec37: assert property (
        $onehot(req_i) && req_i.timer_match_b_req[3] |=> grant_o.vector == 6'h25
    ) else $error("vector 37 map wrong");

    a_map_vec38: assert property (
        $onehot(req_i) && req_i.timer_overflow_req[3] |=> grant_o.vector == 6'h26
    ) else $error("vector 38 map wrong");

    a_map_vec41: assert property (
        $onehot(req_i) && req_i.timer_match_b_req[4] |=> grant_o.vector == 6'h29
    ) else $error("vector 41 map wrong");

    a_map_vec42: assert property (
        $onehot(req_i) && req_i.timer_overflow_req[4] |=> grant_o.vector == 6'h2A
    ) else $error("vector 42 map wrong");

    a_map_vec53: assert property (
        $onehot(req_i) && req_i.serial_rx_full_req[0] |=> grant_o.vector == 6'h35
    ) else $error("vector 53 map wrong");

    a_map_vec54: assert property (
        $onehot(req_i) && req_i.serial_tx_empty_req[0] |=> grant_o.vector == 6'h36
    ) else $error("vector 54 map wrong");

    a_map_vec55: assert property (
        $onehot(req_i) && req_i.serial_tx_end_req[0] |=> grant_o.vector == 6'h37
    ) else $error("vector 55 map wrong");

    a_map_vec57: assert property (
        $onehot(req_i) && req_i.serial_rx_full_req[1] |=> grant_o.vector == 6'h39
    ) else $error("vector 57 map wrong");

    a_map_vec58: assert property (
        $onehot(req_i) && req_i.serial_tx_empty_req[1] |=> grant_o.vector == 6'h3A
    ) else $error("vector 58 map wrong");

    a_map_vec59: assert property (
        $onehot(req_i) && req_i.serial_tx_end_req[1] |=> grant_o.vector == 6'h3B
    ) else $error("vector 59 map wrong");

    // ****************************************
    // Checks: reset and register port
    // ****************************************

    a_reset_levels: assert property (@(posedge clock_i) disable iff (1'b0)
        !rst_n_i |=> levels == 16'h0000 && !grant_o.valid
    ) else $error("level bits not clear after reset");

    a_level_a_write: assert property (
        wr_i && addr_i == OFS_LEVEL_A |=> level_a_reg == ($past(wdata_i) & 8'hDF)
    ) else $error("level A write wrong");

    a_level_b_write: assert property (
        wr_i && addr_i == OFS_LEVEL_B |=> level_b_reg == ($past(wdata_i) & 8'hCE)
    ) else $error("level B write wrong");

    a_level_a_read: assert property (
        rd_i && addr_i == OFS_LEVEL_A |=> rdata_o == $past(level_a_reg)
    ) else $error("level A read wrong");

    a_level_b_read: assert property (
        rd_i && addr_i == OFS_LEVEL_B |=> rdata_o == $past(level_b_reg)
    ) else $error("level B read wrong");

    a_control_read: assert property (
        rd_i && addr_i == OFS_CONTROL |=> rdata_o == {7'h00, $past(wide_reg)}
    ) else $error("control read wrong");

    a_status_read: assert property (
        rd_i && addr_i == OFS_STATUS
        |=> rdata_o == {$past(grant_o.valid), $past(grant_o.is_nmi), $past(grant_o.vector)}
    ) else $error("status read wrong");

endmodule : intvec_resolver

`default_nettype wire

// *** intvec_pkg.sv ***
// Purpose: Constants and types for the interrupt vector and priority resolver.
// Assumes: 8-bit register port, 50 MHz system clock.
// Notes: Priority bits are seen as one 16-bit word {level A, level B}.
`default_nettype none

package intvec_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] OFS_LEVEL_A = 4'h0;
    localparam logic [3:0] OFS_LEVEL_B = 4'h1;
    localparam logic [3:0] OFS_CONTROL = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [7:0] LEVEL_A_MASK = 8'hDF;
    localparam logic [7:0] LEVEL_B_MASK = 8'hCE;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam int CTRL_WIDE_BIT = 0;

    // ****************************************
    // Vector numbers
    // ****************************************
    localparam logic [5:0] VEC_NMI = 6'h07;
    localparam logic [5:0] VEC_EXT0 = 6'h0C;
    localparam logic [5:0] VEC_EXT1 = 6'h0D;
    localparam logic [5:0] VEC_EXT4 = 6'h10;
    localparam logic [5:0] VEC_EXT5 = 6'h11;
    localparam logic [5:0] VEC_WDT = 6'h14;
    localparam int VEC_TMR_BASE = 24;
    localparam int VEC_SER_BASE = 52;
    localparam int VEC_STRIDE = 4;
    localparam logic [5:0] VEC_ADC = 6'h3C;

    // ****************************************
    // Level bit positions in {level A, level B}
    // ****************************************
    localparam int LVL_EXT0 = 15;
    localparam int LVL_EXT1 = 14;
    localparam int LVL_EXT45 = 12;
    localparam int LVL_WDT = 11;
    localparam int LVL_TMR0 = 10;
    localparam int LVL_SER0 = 3;
    localparam int LVL_ADC = 1;

    localparam int NUM_TMR = 5;
    localparam int NUM_SER = 2;

    typedef struct packed {
        logic nmi_req;
        logic ext0_req;
        logic ext1_req;
        logic ext4_req;
        logic ext5_req;
        logic watchdog_interval_req;
        logic [NUM_TMR-1:0] timer_match_a_req;
        logic [NUM_TMR-1:0] timer_match_b_req;
        logic [NUM_TMR-1:0] timer_overflow_req;
        logic [NUM_SER-1:0] serial_rx_error_req;
        logic [NUM_SER-1:0] serial_rx_full_req;
        logic [NUM_SER-1:0] serial_tx_empty_req;
        logic [NUM_SER-1:0] serial_tx_end_req;
        logic conversion_end_req;
    } req_t;

    typedef struct packed {
        logic valid;
        logic is_nmi;
        logic [5:0] vector;
        logic [31:0] address;
    } grant_t;

    // Table entry address, low 16 bits only
    function automatic logic [15:0] vec_addr(input logic [5:0] vec, input logic wide);
        vec_addr = wide ? {8'h00, vec, 2'h0} : {9'h000, vec, 1'h0};
    endfunction : vec_addr

    // Lowest set index, for smallest vector first
    function automatic logic [6:0] first_set(input logic [63:0] m);
        first_set = 7'h00;
        for (int i = 63; i >= 0; i--) begin
            if (m[i]) begin
                first_set = {1'b1, 6'(i)};
            end
        end
    endfunction : first_set

endpackage : intvec_pkg

`default_nettype wire

// *** cpu_core_model.sv ***
// Purpose: Model of the CPU core that fetches the granted vector.
// Assumes: Grant is a level with one winner at a time.
// Notes: Keeps the table address of the last vector it fetched.
`default_nettype none

module cpu_core_model
    import intvec_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire grant_t grant_i,
    output logic [31:0] fetch_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Fetch from the table whenever a winner is offered
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fetch_addr_o <= 32'h00000000;
        end else if (grant_i.valid) begin
            fetch_addr_o <= grant_i.address;
        end
    end
endmodule : cpu_core_model

`default_nettype wire

// *** interrupt_vector_priority_bench.sv ***
// Purpose: Self-checking bench of the vector and priority resolver.
// Assumes: Grant follows requests and level writes within three edges.
// Notes: Sources are numbered 0..29 in default order.
`default_nettype none

module interrupt_vector_priority_bench
    import intvec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    req_t req_i = '0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    grant_t grant_o;
    logic [31:0] fetch_addr;
    int n_errors = 0;
    int n_tests = 0;
    logic wide = 1'b0;
    req_t r, all;
    logic [5:0] v, ve, v2;
    int lvl, lvl2;
    logic [7:0] d;
    logic [15:0] lw;

    always #10 clock_i = ~clock_i;

    intvec_resolver dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .grant_o(grant_o));
    cpu_core_model cpu_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .grant_i(grant_o),
        .fetch_addr_o(fetch_addr));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop();
        if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= dat;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] dat);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        dat = rdata_o;
    endtask : rd

    task automatic drive(input req_t rq);
        @(posedge clock_i);
        req_i <= rq;
        repeat (3) @(posedge clock_i);
        #1;
    endtask : drive

    // Request, vector and level bit of source k
    task automatic src(input int k, output req_t rq, output logic [5:0] vo, output int lo);
        int t;
        int j;
        rq = '0;
        t = (k < 21) ? (k - 6) / 3 : (k - 21) / 4;
        j = (k < 21) ? (k - 6) % 3 : (k - 21) % 4;
        case (k)
            0: begin rq.nmi_req = 1'b1; vo = 6'h07; lo = -1; end
            1: begin rq.ext0_req = 1'b1; vo = 6'h0C; lo = 15; end
            2: begin rq.ext1_req = 1'b1; vo = 6'h0D; lo = 14; end
            3: begin rq.ext4_req = 1'b1; vo = 6'h10; lo = 12; end
            4: begin rq.ext5_req = 1'b1; vo = 6'h11; lo = 12; end
            5: begin rq.watchdog_interval_req = 1'b1; vo = 6'h14; lo = 11; end
            29: begin rq.conversion_end_req = 1'b1; vo = 6'h3C; lo = 1; end
            default: begin
                if (k < 21) begin
                    vo = 6'(24 + 4 * t + j);
                    lo = 10 - t;
                    if (j == 0) rq.timer_match_a_req[t] = 1'b1;
                    else if (j == 1) rq.timer_match_b_req[t] = 1'b1;
                    else rq.timer_overflow_req[t] = 1'b1;
                end else begin
                    vo = 6'(52 + 4 * t + j);
                    lo = 3 - t;
                    if (j == 0) rq.serial_rx_error_req[t] = 1'b1;
                    else if (j == 1) rq.serial_rx_full_req[t] = 1'b1;
                    else if (j == 2) rq.serial_tx_empty_req[t] = 1'b1;
                    else rq.serial_tx_end_req[t] = 1'b1;
                end
            end
        endcase
    endtask : src

    function automatic logic [39:0] exp_grant(input logic [5:0] vi, input logic nmi);
        exp_grant = {1'b1, nmi, vi, 16'h0000, 16'(vi) * (wide ? 16'h0004 : 16'h0002)};
    endfunction : exp_grant

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        chk(grant_o, 40'h0000000000);
        for (int a = 0; a < 4; a++) begin
            rd(4'(a), d);
            chk(40'(d), 40'h0000000000);
        end
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CONTROL, 8'(m));
            wide = m[0];
            rd(OFS_CONTROL, d);
            chk(40'(d), 40'(m));
            for (int k = 0; k < 30; k++) begin
                src(k, r, v, lvl);
                drive(r);
                chk(grant_o, exp_grant(v, k == 0));
                chk(40'(fetch_addr), 40'(32'(exp_grant(v, k == 0))));
            end
        end
        wr(OFS_CONTROL, 8'h00);
        wide = 1'b0;
        for (int k = 0; k < 30; k++) begin
            all = '0;
            for (int j = k; j < 30; j++) begin
                src(j, r, v, lvl);
                all = req_t'(all | r);
            end
            src(k, r, v, lvl);
            drive(all);
            chk(grant_o, exp_grant(v, k == 0));
        end
        all = '0;
        for (int j = 1; j < 30; j++) begin
            src(j, r, v, lvl);
            all = req_t'(all | r);
        end
        for (int k = 1; k < 30; k++) begin
            src(k, r, v, lvl);
            lw = 16'h0001 << lvl;
            wr(OFS_LEVEL_A, lw[15:8]);
            wr(OFS_LEVEL_B, lw[7:0]);
            for (int j = 29; j > 0; j--) begin
                src(j, r, v2, lvl2);
                if (lvl2 == lvl) ve = v2;
            end
            drive(all);
            chk(grant_o, exp_grant(ve, 1'b0));
        end
        src(0, r, v, lvl);
        drive(req_t'(all | r));
        chk(grant_o, exp_grant(6'h07, 1'b1));
        rd(OFS_STATUS, d);
        chk(40'(d), 40'h00000000C7);
        wr(OFS_LEVEL_A, 8'hFF);
        wr(OFS_LEVEL_B, 8'hFF);
        wr(4'h5, 8'hFF);
        rd(OFS_LEVEL_A, d);
        chk(40'(d), 40'h00000000DF);
        rd(OFS_LEVEL_B, d);
        chk(40'(d), 40'h00000000CE);
        rd(4'h5, d);
        chk(40'(d), 40'h0000000000);
        drive(all);
        chk(grant_o, exp_grant(6'h0C, 1'b0));
        wr(OFS_LEVEL_A, 8'h10);
        wr(OFS_LEVEL_B, 8'h00);
        src(1, all, v, lvl);
        src(4, r, v, lvl);
        drive(req_t'(all | r));
        chk(grant_o, exp_grant(6'h11, 1'b0));
        report_and_stop();
    end

    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule : interrupt_vector_priority_bench

`default_nettype wire
